//--- serial_prog_map.vh
`ifndef SERIAL_PROG_MAP_VH
`define SERIAL_PROG_MAP_VH

`define OP_NOP        4'h0
`define OP_RD_BASE    2'h2
`define OP_WR_BASE    2'h3
`define PTR_KEEP      2'h0
`define PTR_POSTINC   2'h1
`define PTR_POSTDEC   2'h2
`define PTR_PREINC    2'h3
`define OPCODE_BITS   5'h04
`define WORD_BITS     5'h10
`define EXEC_CLKS     5'h04
`define RD_EXEC_CLKS  5'h08
`define RD_OUT_CLKS   5'h08
`define PTR_RESET     22'h000000
`define LATCH_RESET   8'h00

`endif

//--- pin_edge_sync.v
`timescale 1ns/1ns
module pin_edge_sync
(
	input  wire clk_i,
	input  wire reset_i,
	input  wire sclk_pin_i,
	input  wire sdata_pin_i,
	output reg  data_o,
	output reg  rise_o
);
	reg [1:0] clk_sync_r;
	reg [1:0] dat_sync_r;
	reg       clk_prev_r;

	// second stage only feeds logic; first stage stays isolated
	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			clk_sync_r <= 2'h0;
			dat_sync_r <= 2'h0;
			clk_prev_r <= 1'b0;
			data_o     <= 1'b0;
			rise_o     <= 1'b0;
		end
		else
		begin
			clk_sync_r <= {clk_sync_r[0], sclk_pin_i};
			dat_sync_r <= {dat_sync_r[0], sdata_pin_i};
			clk_prev_r <= clk_sync_r[1];
			rise_o     <= clk_sync_r[1] & ~clk_prev_r;
			data_o     <= dat_sync_r[1];
		end
	end
endmodule // pin_edge_sync

//--- serial_program_instruction_port.v
// Overview of operation
// RULE1 - programmer enters mode with high voltage on reset pin, clock and data low
// RULE2 - data bits are sampled on each rising serial clock edge
// RULE3 - instructions and data move least significant bit first both ways
// RULE4 - in this mode no instruction comes from program memory
// RULE5 - table pointer is the address, changed only by table op side effects
// RULE6 - next short opcode is shifted while previous instruction executes
// RULE7 - short opcode fills low four bits, upper twelve bits zero
// RULE8 - opcodes 1000..1011 are table reads: keep, post-inc, post-dec, pre-inc
// RULE9 - opcodes 1100..1111 are table writes: keep, post-inc, post-dec, pre-inc; code steps post-inc and post-dec with the write pulse, like pre-inc
// RULE10 - opcode 0000 is a no-op that loads a following 16-bit instruction
// RULE11 - other special opcodes execute as no-ops
// RULE12 - cpu idles under this machine, clocked only by the serial clock
// RULE13 - first serial clock transition after reset is discarded
// RULE14 - a forced idle op runs while the first opcode is shifted in
// RULE15 - after a no-op the cpu waits until 16 instruction bits arrive
// RULE16 - after a table write the cpu waits while 16 data bits arrive
// RULE17 - table read executes eight clocks, then latch shifts out eight clocks
// RULE18 - after sixteen clocks the next opcode is fetched during execution
// RULE19 - read-back is the 8-bit table latch on the data pin
// RULE20 - a loaded 16-bit instruction executes during the next four clocks
// RULE21 - programmer never sends table ops as full 16-bit instructions
// RULE22 - device drives data pin only during read-out half of a table read
`timescale 1ns/1ns
`include "serial_prog_map.vh"
module serial_program_instruction_port
(
	input  wire        clk_i,
	input  wire        reset_i,
	input  wire        prog_mode_i,
	input  wire        serial_clock_pin_i,
	input  wire        serial_data_pin_i,
	input  wire [7:0]  table_latch_i,
	output reg         serial_data_pin_o,
	output reg         serial_data_pin_oe_o,
	output reg         cpu_clk_pulse_o,
	output reg         cpu_exec_o,
	output reg         forced_idle_op_o,
	output reg  [15:0] instr_o,
	output reg         instr_valid_o,
	output reg         table_write_o,
	output reg         table_read_o,
	output reg  [15:0] write_data_o,
	output reg  [21:0] table_pointer_o
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_FIRST = 3'h1;
	localparam ST_OPC   = 3'h2;
	localparam ST_WORD  = 3'h3;
	localparam ST_WDATA = 3'h4;
	localparam ST_REXEC = 3'h5;
	localparam ST_ROUT  = 3'h6;

	wire       din;
	wire       rise;
	reg  [2:0] state_r;
	reg  [2:0] state_nxt;
	reg  [4:0] cnt_r;
	reg  [15:0] shift_r;
	reg  [3:0] op_r;
	reg  [7:0] out_r;
	reg        exec_pend_r;
	reg        mode_q1_r;
	reg        mode_q2_r;
	reg        mode_prev_r;
	wire [15:0] shifted;
	wire [3:0] op_in;
	wire       op_is_rd;
	wire       op_is_wr;

	pin_edge_sync u_sync
	(
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.sclk_pin_i  (serial_clock_pin_i),
		.sdata_pin_i (serial_data_pin_i),
		.data_o      (din),
		.rise_o      (rise)
	);

	// rising edges only, lsb arrives first so shift right
	assign shifted  = {din, shift_r[15:1]}; // RULE2 RULE3
	assign op_in    = shifted[15:12];
	assign op_is_rd = (op_r[3:2] == `OP_RD_BASE); // RULE8
	assign op_is_wr = (op_r[3:2] == `OP_WR_BASE); // RULE9

	// mode level is from the high-voltage detector, another domain
	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			mode_q1_r   <= 1'b0;
			mode_q2_r   <= 1'b0;
			mode_prev_r <= 1'b0;
		end
		else
		begin
			mode_q1_r   <= prog_mode_i;
			mode_q2_r   <= mode_q1_r;
			mode_prev_r <= mode_q2_r;
		end
	end

	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
			begin
				if (mode_q2_r & ~mode_prev_r)
					state_nxt = ST_FIRST;
			end
			ST_FIRST:
			begin
				if (rise)
					state_nxt = ST_OPC; // RULE13
			end
			ST_OPC:
			begin
				if (rise && cnt_r == `OPCODE_BITS - 5'h01)
				begin
					if (op_in[3:2] == `OP_WR_BASE)
						state_nxt = ST_WDATA; // RULE16
					else if (op_in[3:2] == `OP_RD_BASE)
						state_nxt = ST_REXEC; // RULE17
					else if (op_in == `OP_NOP)
						state_nxt = ST_WORD; // RULE10 RULE15
					else
						state_nxt = ST_OPC; // RULE11
				end
			end
			ST_WORD, ST_WDATA:
			begin
				if (rise && cnt_r == `WORD_BITS - 5'h01)
					state_nxt = ST_OPC; // RULE18
			end
			ST_REXEC:
			begin
				if (rise && cnt_r == `RD_EXEC_CLKS - 5'h01)
					state_nxt = ST_ROUT;
			end
			ST_ROUT:
			begin
				if (rise && cnt_r == `RD_OUT_CLKS - 5'h01)
					state_nxt = ST_OPC; // RULE18
			end
			default:
				state_nxt = ST_IDLE;
		endcase
		if (!mode_q2_r)
			state_nxt = ST_IDLE;
	end

	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			state_r              <= ST_IDLE;
			cnt_r                <= 5'h00;
			shift_r              <= 16'h0000;
			op_r                 <= `OP_NOP;
			out_r                <= `LATCH_RESET;
			exec_pend_r          <= 1'b0;
			serial_data_pin_o    <= 1'b0;
			serial_data_pin_oe_o <= 1'b0;
			cpu_clk_pulse_o      <= 1'b0;
			cpu_exec_o           <= 1'b0;
			forced_idle_op_o     <= 1'b0;
			instr_o              <= 16'h0000;
			instr_valid_o        <= 1'b0;
			table_write_o        <= 1'b0;
			table_read_o         <= 1'b0;
			write_data_o         <= 16'h0000;
			table_pointer_o      <= `PTR_RESET;
		end
		else
		begin
			state_r       <= state_nxt;
			instr_valid_o <= 1'b0;
			table_write_o <= 1'b0;
			table_read_o  <= 1'b0;
			// cpu ticks only from the serial clock, never fetches on its own
			cpu_clk_pulse_o <= rise & cpu_exec_o; // RULE12 RULE4
			// undecoded opcode stays in fetch, so the bit count must restart
			if (state_r != state_nxt)
				cnt_r <= 5'h00;
			else if (rise && state_r == ST_OPC && cnt_r == `OPCODE_BITS - 5'h01)
				cnt_r <= 5'h00; // RULE11
			else if (rise)
				cnt_r <= cnt_r + 5'h01;
			if (rise)
				shift_r <= shifted;
			case (state_r)
				ST_IDLE:
				begin
					cpu_exec_o       <= 1'b0; // RULE12
					forced_idle_op_o <= 1'b0;
					exec_pend_r      <= 1'b0;
				end
				ST_FIRST:
				begin
					if (rise)
						forced_idle_op_o <= 1'b1; // RULE14
				end
				ST_OPC:
				begin
					// loaded word runs for four clocks while the opcode shifts
					if (rise && exec_pend_r && cnt_r == `EXEC_CLKS - 5'h01)
					begin
						cpu_exec_o  <= 1'b0; // RULE20 RULE6
						exec_pend_r <= 1'b0;
					end
					if (rise && cnt_r == `OPCODE_BITS - 5'h01)
					begin
						forced_idle_op_o <= 1'b0;
						op_r             <= op_in;
						// upper twelve bits forced low
						instr_o          <= {12'h000, op_in}; // RULE7
						cpu_exec_o       <= 1'b0; // RULE15 RULE16
						if (op_in[3:2] == `OP_RD_BASE)
						begin
							cpu_exec_o   <= 1'b1; // RULE17
							table_read_o <= 1'b1;
							instr_valid_o <= 1'b1;
							if (op_in[1:0] == `PTR_PREINC)
								table_pointer_o <= table_pointer_o + 22'h000001; // RULE5
						end
					end
				end
				ST_WORD:
				begin
					if (rise && cnt_r == `WORD_BITS - 5'h01)
					begin
						instr_o       <= shifted;
						instr_valid_o <= 1'b1;
						cpu_exec_o    <= 1'b1; // RULE20
						exec_pend_r   <= 1'b1;
					end
				end
				ST_WDATA:
				begin
					if (rise && cnt_r == `WORD_BITS - 5'h01 && op_is_wr)
					begin
						write_data_o  <= shifted;
						table_write_o <= 1'b1; // RULE16
						cpu_exec_o    <= 1'b1; // RULE6
						exec_pend_r   <= 1'b1;
						// pre-increment happens before the write address is used
						case (op_r[1:0])
							`PTR_POSTINC, `PTR_PREINC:
								table_pointer_o <= table_pointer_o + 22'h000001; // RULE9
							`PTR_POSTDEC:
								table_pointer_o <= table_pointer_o - 22'h000001;
							default:
								table_pointer_o <= table_pointer_o;
						endcase
					end
				end
				ST_REXEC:
				begin
					if (rise && cnt_r == `RD_EXEC_CLKS - 5'h01 && op_is_rd)
					begin
						out_r                <= table_latch_i; // RULE19
						serial_data_pin_o    <= table_latch_i[0]; // RULE3
						serial_data_pin_oe_o <= 1'b1; // RULE22
						cpu_exec_o           <= 1'b0;
						// post-step lands only once the execute half is over
						case (op_r[1:0])
							`PTR_POSTINC:
								table_pointer_o <= table_pointer_o + 22'h000001; // RULE8
							`PTR_POSTDEC:
								table_pointer_o <= table_pointer_o - 22'h000001;
							default:
								table_pointer_o <= table_pointer_o;
						endcase
					end
				end
				ST_ROUT:
				begin
					if (rise)
					begin
						out_r             <= {1'b0, out_r[7:1]};
						serial_data_pin_o <= out_r[1]; // RULE3 RULE19
						if (cnt_r == `RD_OUT_CLKS - 5'h01)
						begin
							serial_data_pin_oe_o <= 1'b0; // RULE22
							serial_data_pin_o    <= 1'b0;
						end
					end
				end
				default:
				begin
					cpu_exec_o <= 1'b0;
				end
			endcase
			// losing the mode voltage releases the pin whatever the state
			if (!mode_q2_r)
				serial_data_pin_oe_o <= 1'b0;
		end
	end
endmodule // serial_program_instruction_port

//--- serial_program_instruction_port_assertions.sv
`timescale 1ns/1ns
module serial_program_instruction_port_assertions
(
	input wire        clk_i,
	input wire        reset_i,
	input wire        prog_mode_i,
	input wire        serial_data_pin_oe_o,
	input wire        cpu_clk_pulse_o,
	input wire        cpu_exec_o,
	input wire [15:0] instr_o,
	input wire        table_write_o,
	input wire        table_read_o,
	input wire [21:0] table_pointer_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	// exec half of a read leaves the pin to the programmer
	sequence s_pin_quiet;
		!serial_data_pin_oe_o [*8];
	endsequence
	sequence s_table_op;
		table_write_o || table_read_o;
	endsequence
	AST_PIN_QUIET_EXEC: assert property (table_read_o |-> s_pin_quiet)
		else $error("pin driven during read execution");
	AST_OP_EXCL: assert property (table_write_o |-> !table_read_o && !serial_data_pin_oe_o)
		else $error("write overlaps read");
	AST_PULSE_SINGLE: assert property (s_table_op |=> !table_write_o && !table_read_o)
		else $error("table pulse too long");
	AST_RD_CODE: assert property (table_read_o |-> ##[0:1] instr_o[15:2] == 14'h0002)
		else $error("read without read opcode");
	AST_WR_CODE: assert property (table_write_o |-> ##[0:1] instr_o[15:2] == 14'h0003)
		else $error("write without write opcode");
	// mode level passes two sync flops before the pin is released
	AST_OE_IN_MODE: assert property (serial_data_pin_oe_o |-> prog_mode_i ||
		$past(prog_mode_i) || $past(prog_mode_i, 2) || $past(prog_mode_i, 3))
		else $error("pin driven outside mode");
	AST_CPU_CLK_GATED: assert property (cpu_clk_pulse_o |-> cpu_exec_o || $past(cpu_exec_o))
		else $error("cpu clocked while suspended");
	AST_PTR_SOURCE: assert property ($changed(table_pointer_o) |->
		table_write_o || cpu_exec_o || serial_data_pin_oe_o)
		else $error("pointer moved outside table op");
endmodule // serial_program_instruction_port_assertions

//--- serial_programmer.sv
`timescale 1ns/1ns
module serial_programmer
(
	output reg  sclk_o,
	output reg  sdata_o,
	input  wire pin_i
);
	initial
	begin
		sclk_o = 1'b0;
		sdata_o = 1'b0;
	end
	task pulse;
	begin
		sclk_o = 1'b1;
		#63;
		sclk_o = 1'b0;
		#62;
	end
	endtask
	task shift(input integer n, input [15:0] v);
		integer i;
	begin
		for (i = 0; i < n; i = i + 1)
		begin
			sdata_o = v[i];
			pulse;
		end
	end
	endtask
	// reads go out only as short opcodes
	task read(input [1:0] m, output [7:0] b);
		integer i;
	begin
		shift(4, {12'h000, 2'h2, m});
		sdata_o = 1'b0;
		for (i = 0; i < 16; i = i + 1)
		begin
			if (i > 7)
				sdata_o = ~sdata_o;
			sclk_o = 1'b1;
			#63;
			if (i > 6 && i < 15)
				b[i - 7] = pin_i;
			sclk_o = 1'b0;
			#62;
		end
	end
	endtask
endmodule // serial_programmer

//--- serial_program_instruction_port_tb_top.sv
`timescale 1ns/1ns
module serial_program_instruction_port_tb_top;
	reg         clk_i = 1'b0;
	reg         reset_i = 1'b1;
	reg         prog_mode_i = 1'b0;
	reg  [7:0]  table_latch_i = 8'h00;
	wire        sclk, sdata, pin_o, pin_oe, cpu_pulse, cpu_exec, forced_idle_op, ivalid, wr, rd;
	wire [15:0] instr, wdata;
	wire [21:0] ptr;
	wire        pin = pin_oe ? pin_o : sdata;
	integer     miscompares = 0, checked = 0, pulses = 0, m;
	integer     wr_seen = 0, rd_seen = 0, wr_exp = 0, rd_exp = 0;
	reg  [15:0] last_instr;
	reg  [21:0] p = 22'h000000;
	reg  [7:0]  b;
	serial_program_instruction_port i_dut
	(
		.clk_i(clk_i), .reset_i(reset_i), .prog_mode_i(prog_mode_i),
		.serial_clock_pin_i(sclk), .serial_data_pin_i(pin), .table_latch_i(table_latch_i),
		.serial_data_pin_o(pin_o), .serial_data_pin_oe_o(pin_oe), .cpu_clk_pulse_o(cpu_pulse),
		.cpu_exec_o(cpu_exec), .forced_idle_op_o(forced_idle_op), .instr_o(instr),
		.instr_valid_o(ivalid), .table_write_o(wr), .table_read_o(rd),
		.write_data_o(wdata), .table_pointer_o(ptr)
	);
	serial_programmer i_programmer (.sclk_o(sclk), .sdata_o(sdata), .pin_i(pin));
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		if (cpu_pulse)
			pulses <= pulses + 1;
		if (ivalid)
			last_instr <= instr;
		if (wr)
			wr_seen <= wr_seen + 1;
		if (rd)
			rd_seen <= rd_seen + 1;
	end
	task check(input string name, input [31:0] seen, input [31:0] exp);
	begin
		checked = checked + 1;
		if (seen !== exp)
		begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	end
	endtask
	task finish_test;
	begin
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	task settle;
	begin
		repeat (10) @(posedge clk_i);
		#1;
	end
	endtask
	task step_ptr(input integer md);
	begin
		p = p + ((md == 2) ? 22'h3fffff : {21'h000000, md != 0});
	end
	endtask
	task t_entry;
	begin
		@(posedge clk_i);
		#1 prog_mode_i = 1'b1;
		settle;
		i_programmer.pulse;
		settle;
		check("forced_idle", forced_idle_op, 1);
		check("cpu_exec", cpu_exec, 0);
	end
	endtask
	task t_nop;
	begin
		i_programmer.shift(3, 16'h0000);
		check("forced_idle", forced_idle_op, 1);
		i_programmer.shift(1, 16'h0000);
		check("forced_idle", forced_idle_op, 0);
		i_programmer.shift(16, 16'h5a3c);
		settle;
		check("instr", last_instr, 16'h5a3c);
		check("cpu_exec", cpu_exec, 1);
		pulses = 0;
		i_programmer.shift(4, 16'h0000);
		check("cpu_pulses", pulses, 4);
		i_programmer.shift(16, 16'h4e21);
		settle;
		check("instr", last_instr, 16'h4e21);
		check("ptr", ptr, p);
	end
	endtask
	task t_write(input [1:0] md, input [15:0] d);
	begin
		i_programmer.shift(4, {12'h000, 2'h3, md});
		i_programmer.shift(16, d);
		settle;
		step_ptr(md);
		wr_exp = wr_exp + 1;
		check("table_write", wr_seen, wr_exp);
		check("wdata", wdata, d);
		check("ptr", ptr, p);
	end
	endtask
	task t_read(input [1:0] md);
	begin
		@(posedge clk_i);
		#1 table_latch_i = 8'h96 ^ {6'h00, md};
		i_programmer.read(md, b);
		settle;
		step_ptr(md);
		rd_exp = rd_exp + 1;
		check("table_read", rd_seen, rd_exp);
		check("pin_oe", pin_oe, 0);
		check("rdata", b, 8'h96 ^ {6'h00, md});
		check("ptr", ptr, p);
	end
	endtask
	// undefined special opcode must fall straight back to opcode fetch
	task t_unknown;
	begin
		i_programmer.shift(4, 16'h0006);
		settle;
		check("ptr", ptr, p);
		check("instr_o", instr, 16'h0006);
		check("cpu_exec", cpu_exec, 0);
		check("table_write", wr_seen, wr_exp);
		check("table_read", rd_seen, rd_exp);
		t_write(2'h0, 16'h7e81);
	end
	endtask
	initial
	begin
		repeat (20) @(posedge clk_i);
		#1 reset_i = 1'b0;
		t_entry;
		t_nop;
		for (m = 0; m < 4; m = m + 1)
			t_write(m[1:0], 16'hc3a0 + m[15:0]);
		for (m = 0; m < 4; m = m + 1)
			t_read(m[1:0]);
		t_unknown;
		finish_test;
	end
	initial
	begin
		#400000;
		miscompares = miscompares + 1;
		finish_test;
	end
endmodule // serial_program_instruction_port_tb_top
bind serial_program_instruction_port serial_program_instruction_port_assertions i_chk
(
	.clk_i(clk_i), .reset_i(reset_i), .prog_mode_i(prog_mode_i),
	.serial_data_pin_oe_o(serial_data_pin_oe_o), .cpu_clk_pulse_o(cpu_clk_pulse_o),
	.cpu_exec_o(cpu_exec_o), .instr_o(instr_o), .table_write_o(table_write_o),
	.table_read_o(table_read_o), .table_pointer_o(table_pointer_o)
);
